// [logic/irq_prio_pkg.sv]
package irq_prio_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_ENABLE_ONE = 12'h000;
	localparam logic [11:0] OFS_ENABLE_TWO = 12'h004;
	localparam logic [11:0] OFS_ENABLE_THREE = 12'h008;
	localparam logic [11:0] OFS_PRIORITY_ONE = 12'h00C;
	localparam logic [11:0] OFS_PRIORITY_TWO = 12'h010;
	localparam logic [11:0] OFS_PRIORITY_THREE = 12'h014;
	localparam logic [11:0] OFS_CONTROL = 12'h018;
	localparam logic [11:0] OFS_FLAGS = 12'h01C;
	localparam logic [11:0] OFS_REQUESTS = 12'h020;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int NUM_SOURCES = 24;
	// Writable bits per register
	localparam logic [7:0] WMASK_ONE = 8'hFF;
	localparam logic [7:0] WMASK_TWO = 8'hCF;
	localparam logic [7:0] WMASK_THREE = 8'h01;
	// Implemented (readable) bits per register
	localparam logic [7:0] IMPL_ONE = 8'hFF;
	localparam logic [7:0] IMPL_TWO = 8'hCF;
	localparam logic [7:0] IMPL_THREE = 8'h31;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] PRIORITY_RESET = 8'hFF;
	// Control register bits
	localparam int CTRL_PRIO_ON_BIT = 0;
	localparam int CTRL_PERIPH_GATE_BIT = 1;
	localparam int CTRL_GLOBAL_GATE_BIT = 2;

	// ------------------------------------------------------------
	// Bus encodings
	// ------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

	typedef struct packed {
		logic [7:0] three;
		logic [7:0] two;
		logic [7:0] one;
	} src_vec_t;

	typedef struct packed {
		logic global_gate;
		logic periph_gate;
		logic prio_on;
	} ctrl_t;

endpackage

// [logic/periph_irq_enable_priority.sv]
// Chosen here: the AHB-Lite slave port and the register offsets.
module periph_irq_enable_priority
	import irq_prio_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire src_vec_t PERIPH_FLAGS,
	output logic IRQ_HIGH,
	output logic IRQ_LOW,
	output ctrl_t CTRL_STATE
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	src_vec_t enables;
	src_vec_t priorities;
	ctrl_t ctrl;
	src_vec_t active;
	logic wr_pending;
	logic [11:0] wr_addr;
	logic [31:0] next_rdata;
	logic [11:0] addr_lo;
	logic accept;

	assign addr_lo = HADDR[11:0];
	assign accept = HSEL && HREADY &&
		(HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

	// ------------------------------------------------------------
	// Bus response: always zero wait, always OKAY
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Writes land in the data phase, so capture the address first
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wr_pending <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			wr_pending <= accept && HWRITE;
			wr_addr <= addr_lo;
		end
	end

	// ------------------------------------------------------------
	// Enable registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			enables <= {ENABLE_RESET, ENABLE_RESET, ENABLE_RESET};
		end else if (wr_pending) begin
			case (wr_addr)
				OFS_ENABLE_ONE: begin
					enables.one <= HWDATA[7:0] & WMASK_ONE;
				end
				OFS_ENABLE_TWO: begin
					enables.two <= HWDATA[7:0] & WMASK_TWO;
				end
				OFS_ENABLE_THREE: begin
					// Read-only bits keep their value
					enables.three <= (HWDATA[7:0] & WMASK_THREE) |
						(enables.three & ~WMASK_THREE);
				end
				default: begin
					enables <= enables;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Priority registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			priorities.one <= PRIORITY_RESET & IMPL_ONE;
			priorities.two <= PRIORITY_RESET & IMPL_TWO;
			priorities.three <= PRIORITY_RESET & IMPL_THREE;
		end else if (wr_pending) begin
			case (wr_addr)
				OFS_PRIORITY_ONE: begin
					priorities.one <= HWDATA[7:0] & WMASK_ONE;
				end
				OFS_PRIORITY_TWO: begin
					priorities.two <= HWDATA[7:0] & WMASK_TWO;
				end
				OFS_PRIORITY_THREE: begin
					priorities.three <= (HWDATA[7:0] & WMASK_THREE) |
						(priorities.three & ~WMASK_THREE);
				end
				default: begin
					priorities <= priorities;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ctrl <= '0;
		end else if (wr_pending && wr_addr == OFS_CONTROL) begin
			ctrl.prio_on <= HWDATA[CTRL_PRIO_ON_BIT];
			ctrl.periph_gate <= HWDATA[CTRL_PERIPH_GATE_BIT];
			ctrl.global_gate <= HWDATA[CTRL_GLOBAL_GATE_BIT];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			CTRL_STATE <= '0;
		end else begin
			CTRL_STATE <= ctrl;
		end
	end

	// ------------------------------------------------------------
	// Request forming
	// ------------------------------------------------------------
	// Flags are sampled as they are; no enable gates the flag itself
	assign active = PERIPH_FLAGS & enables;

	// ------------------------------------------------------------
	// Per-source steering
	// ------------------------------------------------------------
	logic [NUM_SOURCES-1:0] hi_req;
	logic [NUM_SOURCES-1:0] lo_req;
	genvar src;
	generate
		for (src = 0; src < NUM_SOURCES; src++) begin : g_steer
			// Unimplemented positions never request, enable stays 0
			assign hi_req[src] = active[src] && priorities[src];
			assign lo_req[src] = active[src] && !priorities[src];
		end
	endgenerate

	// Single-level mode: peripheral gate and global gate, all to high
	// Two-level mode: priority steers, global gate on high, peripheral gate on low
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			IRQ_HIGH <= 1'b0;
			IRQ_LOW <= 1'b0;
		end else if (ctrl.prio_on) begin
			IRQ_HIGH <= ctrl.global_gate && |hi_req;
			IRQ_LOW <= ctrl.periph_gate && |lo_req;
		end else begin
			IRQ_HIGH <= ctrl.global_gate && ctrl.periph_gate
				&& |active;
			IRQ_LOW <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read data, registered for the data phase
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (addr_lo)
			OFS_ENABLE_ONE: next_rdata[7:0] = enables.one & IMPL_ONE;
			OFS_ENABLE_TWO: next_rdata[7:0] = enables.two & IMPL_TWO;
			OFS_ENABLE_THREE: next_rdata[7:0] = enables.three & IMPL_THREE;
			OFS_PRIORITY_ONE: next_rdata[7:0] = priorities.one & IMPL_ONE;
			OFS_PRIORITY_TWO: next_rdata[7:0] = priorities.two & IMPL_TWO;
			OFS_PRIORITY_THREE: begin
				next_rdata[7:0] = priorities.three & IMPL_THREE;
			end
			OFS_CONTROL: next_rdata[2:0] = ctrl;
			OFS_FLAGS: next_rdata[23:0] = PERIPH_FLAGS;
			OFS_REQUESTS: next_rdata[23:0] = active;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			HRDATA <= 32'h0000_0000;
		end else if (accept && !HWRITE) begin
			HRDATA <= next_rdata;
		end
	end

endmodule

// [tb/flag_source_model.sv]
module flag_source_model
	import irq_prio_pkg::*;
(
	input wire logic clk,
	input wire src_vec_t set_v,
	input wire src_vec_t clr_v,
	output src_vec_t flags
);
	timeunit 1ns;
	timeprecision 1ns;
	initial flags = '0;
	// Set wins over clear, enables never matter here
	// Clear input lets software drop a stale flag before enabling
	always @(posedge clk) flags <= (flags & ~clr_v) | set_v;
endmodule

// [tb/irq_prio_assertions.sv]
module irq_prio_assertions
	import irq_prio_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire src_vec_t PERIPH_FLAGS,
	input wire logic IRQ_HIGH,
	input wire logic IRQ_LOW,
	input wire ctrl_t CTRL_STATE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	logic rd;
	assign rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
	property p_rst; $fell(SYS_RST) |-> CTRL_STATE == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("ctrl not clear");
	property p_lo; !CTRL_STATE.prio_on |-> !IRQ_LOW; endproperty
	a_lo: assert property (p_lo) else $error("low in flat mode");
	property p_gate;
		!CTRL_STATE.prio_on && !CTRL_STATE.periph_gate |-> !IRQ_HIGH;
	endproperty
	a_gate: assert property (p_gate) else $error("ungated");
	property p_hig;
		CTRL_STATE.prio_on && !CTRL_STATE.global_gate |-> !IRQ_HIGH;
	endproperty
	a_hig: assert property (p_hig) else $error("high ungated");
	property p_nof; PERIPH_FLAGS == '0 |=> !IRQ_HIGH && !IRQ_LOW; endproperty
	a_nof: assert property (p_nof) else $error("request no flag");
	property p_en2;
		rd && HADDR[11:0] == OFS_ENABLE_TWO |=> HRDATA[5:4] == 2'h0;
	endproperty
	a_en2: assert property (p_en2) else $error("enable two gap");
	property p_en3;
		rd && HADDR[11:0] == OFS_ENABLE_THREE |=> HRDATA[31:1] == 31'h0;
	endproperty
	a_en3: assert property (p_en3) else $error("enable three");
	property p_pr3;
		rd && HADDR[11:0] == OFS_PRIORITY_THREE |=> HRDATA[7:1] == 7'h18;
	endproperty
	a_pr3: assert property (p_pr3) else $error("priority three");
	c_hi: cover property (IRQ_HIGH);
	c_lo: cover property (IRQ_LOW);
	c_pr3: cover property (rd && HADDR[11:0] == OFS_PRIORITY_THREE);
endmodule
bind periph_irq_enable_priority irq_prio_assertions chk(.REF_CLK, .SYS_RST,
	.HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA, .PERIPH_FLAGS,
	.IRQ_HIGH, .IRQ_LOW, .CTRL_STATE);

// [tb/tb.sv]
module tb
	import irq_prio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic hrdy, irq_hi, irq_lo, hresp;
	ctrl_t cst;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	src_vec_t set_v = '0, clr_v = '0, flags;
	int error_cnt = 0, checks_done = 0;
	logic [11:0] ofs [6] = '{OFS_ENABLE_ONE, OFS_ENABLE_TWO,
		OFS_ENABLE_THREE, OFS_PRIORITY_ONE, OFS_PRIORITY_TWO,
		OFS_PRIORITY_THREE};
	logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hCF, 8'h31};
	logic [7:0] one_v [6] = '{8'hFF, 8'hCF, 8'h01, 8'hFF, 8'hCF, 8'h31};
	logic [7:0] zer_v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30};
	always #10 clk = ~clk;
	flag_source_model fsm(.clk(clk), .set_v(set_v), .clr_v(clr_v),
		.flags(flags));
	periph_irq_enable_priority dut(.REF_CLK(clk), .SYS_RST(rst),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
		.HREADYOUT(hrdy), .HRESP(hresp), .PERIPH_FLAGS(flags),
		.IRQ_HIGH(irq_hi), .IRQ_LOW(irq_lo), .CTRL_STATE(cst));
	// ----
	// Bus and compare helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, {24'h0, e});
	endtask
	task automatic irq(input logic h, input logic l);
		repeat (2) @(posedge clk);
		chk({30'h0, irq_hi, irq_lo}, {30'h0, h, l});
	endtask
	task automatic pulse(input src_vec_t s, input src_vec_t c);
		@(posedge clk);
		set_v <= s;
		clr_v <= c;
		@(posedge clk);
		set_v <= '0;
		clr_v <= '0;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset_values;
		foreach (ofs[i]) rd(ofs[i], rst_v[i]);
		rd(OFS_CONTROL, 8'h00);
		chk({28'h0, hresp, cst}, 32'h0);
	endtask
	task automatic t_reset_again;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
	endtask
	task automatic t_write_masks;
		foreach (ofs[i]) wr(ofs[i], 8'hFF);
		wr(12'h040, 8'hFF);
		foreach (ofs[i]) rd(ofs[i], one_v[i]);
		rd(12'h040, 8'h00);
		foreach (ofs[i]) wr(ofs[i], 8'h00);
		foreach (ofs[i]) rd(ofs[i], zer_v[i]);
	endtask
	task automatic t_requests;
		pulse(24'h000001, '0);
		rd(OFS_FLAGS, 8'h01);
		wr(OFS_CONTROL, 8'h06);
		irq(1'b0, 1'b0);
		chk({29'h0, cst}, 32'h6);
		wr(OFS_ENABLE_ONE, 8'h01);
		irq(1'b1, 1'b0);
		wr(OFS_CONTROL, 8'h04);
		irq(1'b0, 1'b0);
		wr(OFS_PRIORITY_ONE, 8'hFE);
		wr(OFS_CONTROL, 8'h03);
		irq(1'b0, 1'b1);
		wr(OFS_PRIORITY_ONE, 8'h01);
		irq(1'b0, 1'b0);
		wr(OFS_CONTROL, 8'h07);
		irq(1'b1, 1'b0);
		pulse('0, 24'h000001);
		irq(1'b0, 1'b0);
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		t_write_masks();
		t_requests();
		t_reset_again();
		tally_and_finish();
	end
	// Run needs under two hundred cycles; far margin
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
